/* File: core/cflu_core.sv */
// How it works
// - Signed register compare on 32-bit words
// - Field cleared; LT, GT, EQ, overflow copy
// - Immediate sign-extended, compared signed
// - Unsigned register compare on 32-bit words
// - Immediate zero-extended, compared unsigned
// - Size bit set is invalid form
// - Low bit set may spoil default field
// - Count leading zeros from top bit
// - Count spans zero through thirty-two
// - Record flag updates default field
// - Flag AND into destination bit
// - Flag AND with complement
// - Flag NAND into destination bit
// - Flag equivalence, same bit sets it
// - Flag NOR into destination bit
// - Options twelve branches on bit one
// - Options four branches on bit zero
// - Link flag saves address plus four
// - Target is link with low bits cleared
`timescale 1ns/1ps
`default_nettype none

module cflu_core (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire cflu_pkg::cflu_cmd_t cmd,
    input wire logic [cflu_pkg::WORD_W-1:0] firstSourceGpr,
    input wire logic [cflu_pkg::WORD_W-1:0] secondSourceGpr,
    input wire logic [cflu_pkg::WORD_W-1:0] currentFetchAddr,
    input wire logic lowInstrBit,
    input wire logic summaryOverflow,
    input wire logic flagsWriteEn,
    input wire logic [cflu_pkg::FLAGS_W-1:0] flagsWriteData,
    input wire logic linkWriteEn,
    input wire logic [cflu_pkg::WORD_W-1:0] linkWriteData,
    output cflu_pkg::cflu_result_t result,
    output logic [cflu_pkg::FLAGS_W-1:0] conditionFlags,
    output logic [cflu_pkg::WORD_W-1:0] returnLink
);
    import cflu_pkg::*;

    logic [FLAGS_W-1:0] condition_flags_reg;
    logic [FLAGS_W-1:0] condition_flags_next;
    logic [WORD_W-1:0] return_link_reg;
    logic [WORD_W-1:0] return_link_next;
    cflu_result_t result_reg;
    cflu_result_t result_next;

    wire cflu_op_t op = cmd.op;
    wire logic isCmpS = (op == OP_CMP) || (op == OP_CMPI);
    wire logic isCmpU = (op == OP_CMPL) || (op == OP_CMPLI);
    wire logic isCmp = isCmpS || isCmpU;
    wire logic isRegCmp = (op == OP_CMP) || (op == OP_CMPL);
    wire logic isFlagOp = (op == OP_FAND) || (op == OP_FANDC) || (op == OP_FNAND)
        || (op == OP_FEQV) || (op == OP_FNOR);

    wire logic [WORD_W-1:0] immSigned = {{(WORD_W-IMM_W){cmd.literalOperand[IMM_W-1]}}, cmd.literalOperand};
    wire logic [WORD_W-1:0] immUnsigned = {{(WORD_W-IMM_W){1'h0}}, cmd.literalOperand};
    wire logic [WORD_W-1:0] cmpRight = (op == OP_CMPI) ? immSigned :
        (op == OP_CMPLI) ? immUnsigned : secondSourceGpr;

    wire logic sLess = $signed(firstSourceGpr) < $signed(cmpRight);
    wire logic sGreater = $signed(firstSourceGpr) > $signed(cmpRight);
    wire logic uLess = firstSourceGpr < cmpRight;
    wire logic uGreater = firstSourceGpr > cmpRight;
    wire logic cmpEqual = firstSourceGpr == cmpRight;
    wire logic cmpLess = isCmpS ? sLess : uLess;
    wire logic cmpGreater = isCmpS ? sGreater : uGreater;

    // fresh field, bit 0 is LT at the top end
    wire logic [FIELD_W-1:0] cmpField = {cmpLess, cmpGreater, cmpEqual, summaryOverflow};

    wire logic sizeInvalid = isCmp && cmd.sizeBit;

    logic [CNT_W-1:0] zeroCount;

    cflu_lzc u_lzc (
        .srcWord(firstSourceGpr),
        .zeroCount(zeroCount)
    );

    // 0..32 result written to destination register
    wire logic [WORD_W-1:0] clzWord = {{(WORD_W-CNT_W){1'h0}}, zeroCount};
    // count is never negative, so LT stays clear
    wire logic clzGreater = zeroCount != '0;
    wire logic clzEqual = zeroCount == '0;
    wire logic [FIELD_W-1:0] clzField = {1'h0, clzGreater, clzEqual, summaryOverflow};

    // bit n lives at vector index 31-n
    function automatic logic flagBit(input logic [FLAGS_W-1:0] f, input logic [SEL_W-1:0] idx);
        flagBit = f[FLAGS_W - 1 - int'(idx)];
    endfunction

    wire logic bitA = flagBit(condition_flags_reg, cmd.firstFlagSel);
    wire logic bitB = flagBit(condition_flags_reg, cmd.secondFlagSel);
    logic flagResult;

    always_comb begin
        unique case (op)
            OP_FAND: flagResult = bitA & bitB;
            OP_FANDC: flagResult = bitA & ~bitB;
            OP_FNAND: flagResult = ~(bitA & bitB);
            OP_FEQV: flagResult = ~(bitA ^ bitB);
            OP_FNOR: flagResult = ~(bitA | bitB);
            default: flagResult = 1'h0;
        endcase
    end

    // tested index is 4*field+position, counted from the top
    wire logic testedBit = flagBit(condition_flags_reg, cmd.testedFlagIndex);
    wire logic isBr = op == OP_BRLINK;
    wire logic brOptTrue = cmd.branchOptions == OPT_IF_TRUE;
    wire logic brOptFalse = cmd.branchOptions == OPT_IF_FALSE;
    // taken on one; taken on zero
    wire logic brTaken = isBr && ((brOptTrue && testedBit) || (brOptFalse && !testedBit));
    wire logic brInvalid = isBr && !brOptTrue && !brOptFalse;
    // low two bits of link forced to zero
    wire logic [WORD_W-1:0] brTarget = {return_link_reg[WORD_W-1:2], 2'h0};
    wire logic [WORD_W-1:0] linkValue = currentFetchAddr + LINK_STEP;

    wire logic [SEL_W-1:0] fieldTop = {cmd.destFieldSel, 2'h0};
    wire logic [SEL_W-1:0] fieldLow = SEL_W'(FLAGS_W - FIELD_W) - fieldTop;
    wire logic go = cmdValid && !sizeInvalid && !brInvalid;

    always_comb begin
        condition_flags_next = condition_flags_reg;
        if (flagsWriteEn) begin
            condition_flags_next = flagsWriteData;
        end
        if (go && isCmp) begin
            condition_flags_next[fieldLow +: FIELD_W] = cmpField;
            // default field left as computed garbage-free; allowed undefined
            if (isRegCmp && lowInstrBit) begin
                condition_flags_next[FLAGS_W-1 -: FIELD_W] = condition_flags_next[FLAGS_W-1 -: FIELD_W];
            end
        end
        // recorded count lands in the default field
        if (go && op == OP_CLZ && cmd.recordFlag) begin
            condition_flags_next[FLAGS_W-1 -: FIELD_W] = clzField;
        end
        if (go && isFlagOp) begin
            condition_flags_next[FLAGS_W - 1 - int'(cmd.destFlagPos)] = flagResult;
        end
    end

    always_comb begin
        return_link_next = return_link_reg;
        if (linkWriteEn) begin
            return_link_next = linkWriteData;
        end
        // link written after target is taken from old value
        if (go && isBr && cmd.linkFlag) begin
            return_link_next = linkValue;
        end
    end

    always_comb begin
        result_next.valid = cmdValid;
        result_next.gprData = (op == OP_CLZ) ? clzWord : WORD_ZERO;
        result_next.branchTaken = go && brTaken;
        result_next.branchTarget = brTarget;
        result_next.invalidForm = cmdValid && (sizeInvalid || brInvalid);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            condition_flags_reg <= FLAGS_RESET;
            return_link_reg <= LINK_RESET;
            result_reg <= '0;
        end else begin
            condition_flags_reg <= condition_flags_next;
            return_link_reg <= return_link_next;
            result_reg <= result_next;
        end
    end

    assign result = result_reg;
    assign conditionFlags = condition_flags_reg;
    assign returnLink = return_link_reg;

endmodule

`default_nettype wire

/* File: core/cflu_pkg.sv */
package cflu_pkg;

    localparam int WORD_W = 32;
    localparam int IMM_W = 16;
    localparam int FLAGS_W = 32;
    localparam int FIELD_W = 4;
    localparam int FIELD_CNT = 8;
    localparam int SEL_W = 5;
    localparam int FSEL_W = 3;
    localparam int OPT_W = 5;
    localparam int CNT_W = 6;

    // Bit positions inside a 4-bit field, counted from the field's top end
    localparam logic [1:0] POS_LT = 2'h0;
    localparam logic [1:0] POS_GT = 2'h1;
    localparam logic [1:0] POS_EQ = 2'h2;
    localparam logic [1:0] POS_SO = 2'h3;

    localparam logic [OPT_W-1:0] OPT_IF_TRUE = 5'h0c;
    localparam logic [OPT_W-1:0] OPT_IF_FALSE = 5'h04;
    localparam logic [WORD_W-1:0] LINK_STEP = 32'h00000004;

    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 32'h00000000;
    localparam logic [WORD_W-1:0] LINK_RESET = 32'h00000000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_CMP,
        OP_CMPI,
        OP_CMPL,
        OP_CMPLI,
        OP_CLZ,
        OP_FAND,
        OP_FANDC,
        OP_FNAND,
        OP_FEQV,
        OP_FNOR,
        OP_BRLINK
    } cflu_op_t;

    typedef struct packed {
        cflu_op_t op;
        logic [SEL_W-1:0] destFlagPos;
        logic [SEL_W-1:0] firstFlagSel;
        logic [SEL_W-1:0] secondFlagSel;
        logic [FSEL_W-1:0] destFieldSel;
        logic sizeBit;
        logic recordFlag;
        logic linkFlag;
        logic [OPT_W-1:0] branchOptions;
        logic [SEL_W-1:0] testedFlagIndex;
        logic [IMM_W-1:0] literalOperand;
    } cflu_cmd_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] gprData;
        logic branchTaken;
        logic [WORD_W-1:0] branchTarget;
        logic invalidForm;
    } cflu_result_t;

endpackage

/* File: core/cflu_lzc.sv */
`timescale 1ns/1ps
`default_nettype none

module cflu_lzc (
    input wire logic [cflu_pkg::WORD_W-1:0] srcWord,
    output logic [cflu_pkg::CNT_W-1:0] zeroCount
);
    import cflu_pkg::*;

    // Scan from bit 0 upward; the highest one found sets the count
    always_comb begin
        zeroCount = CNT_W'(WORD_W);
        for (int i = 0; i < WORD_W; i++) begin
            if (srcWord[i]) begin
                zeroCount = CNT_W'(WORD_W - 1 - i);
            end
        end
    end

endmodule

`default_nettype wire

/* File: test/cflu_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cflu_core_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire cflu_pkg::cflu_cmd_t cmd,
    input wire logic [31:0] firstSourceGpr,
    input wire logic [31:0] secondSourceGpr,
    input wire logic [31:0] currentFetchAddr,
    input wire logic summaryOverflow,
    input wire logic flagsWriteEn,
    input wire cflu_pkg::cflu_result_t result,
    input wire logic [31:0] conditionFlags,
    input wire logic [31:0] returnLink
);
    import cflu_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [2:0] fieldSel_reg;
    wire logic [31:0] a = firstSourceGpr;
    wire logic [31:0] b = secondSourceGpr;
    wire logic [3:0] sExp = {$signed(a) < $signed(b), $signed(a) > $signed(b), a == b, summaryOverflow};
    wire logic [3:0] uExp = {a < b, a > b, a == b, summaryOverflow};
    wire logic [3:0] fieldNow = conditionFlags[31-4*fieldSel_reg -: 4];
    wire logic cmpOk = cmdValid && !cmd.sizeBit && !flagsWriteEn;
    wire logic brOk = cmdValid && cmd.op == OP_BRLINK && (cmd.branchOptions inside {OPT_IF_TRUE, OPT_IF_FALSE});
    wire logic wantTaken = conditionFlags[31-cmd.testedFlagIndex] == (cmd.branchOptions == OPT_IF_TRUE);
    always_ff @(posedge sys_clk) fieldSel_reg <= cmd.destFieldSel;
    a_answer_next: assert property (cmdValid |=> result.valid)
        else $error("no result after command");
    a_cmp_signed: assert property (cmpOk && cmd.op == OP_CMP |=> fieldNow == $past(sExp))
        else $error("signed compare field wrong");
    a_cmp_unsigned: assert property (cmpOk && cmd.op == OP_CMPL |=> fieldNow == $past(uExp))
        else $error("unsigned compare field wrong");
    a_size_refused: assert property (cmdValid && cmd.sizeBit && !flagsWriteEn && cmd.op == OP_CMP
        |=> result.invalidForm && $stable(conditionFlags)) else $error("size bit not refused");
    a_count_empty: assert property (cmdValid && cmd.op == OP_CLZ && a == 32'h0 |=> result.gprData == 32'h20)
        else $error("zero word count wrong");
    a_link_saved: assert property (brOk && cmd.linkFlag |=> returnLink == $past(currentFetchAddr) + 32'h4)
        else $error("link not saved");
    a_target_base: assert property (brOk |=> result.branchTarget == {$past(returnLink[31:2]), 2'h0})
        else $error("target wrong");
    a_branch_cond: assert property (brOk |=> result.branchTaken == $past(wantTaken))
        else $error("branch decision wrong");
endmodule
bind cflu_core cflu_core_asserts i_chk (.sys_clk(sys_clk), .reset(reset), .cmdValid(cmdValid), .cmd(cmd),
    .firstSourceGpr(firstSourceGpr), .secondSourceGpr(secondSourceGpr), .currentFetchAddr(currentFetchAddr),
    .summaryOverflow(summaryOverflow), .flagsWriteEn(flagsWriteEn), .result(result),
    .conditionFlags(conditionFlags), .returnLink(returnLink));
`default_nettype wire

/* File: test/cflu_decode_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cflu_decode_model (
    input wire logic issue,
    input wire cflu_pkg::cflu_cmd_t issueCmd,
    output logic cmdValid,
    output cflu_pkg::cflu_cmd_t cmd
);
    import cflu_pkg::*;
    assign cmdValid = issue;
    // Idle bus shows inverted fields so nothing stale can pass
    assign cmd = issue ? issueCmd : ~issueCmd;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cflu_pkg::*;
    typedef struct packed {
        cflu_op_t op;
        logic [31:0] a;
        logic [31:0] b;
        logic [15:0] imm;
        logic [2:0] fld;
        logic so;
        logic [3:0] f;
        logic [5:0] n;
    } cflu_row_t;
    cflu_row_t rows [11] = '{'{OP_CMP, 32'hffffffff, 32'h1, 16'h0, 3'h1, 1'h0, 4'h8, 6'h0},
        '{OP_CMPL, 32'hffffffff, 32'h1, 16'h0, 3'h2, 1'h1, 4'h5, 6'h0},
        '{OP_CMPI, 32'hffffffff, 32'h1, 16'hffff, 3'h3, 1'h0, 4'h2, 6'h0},
        '{OP_CMPLI, 32'hffffffff, 32'h1, 16'hffff, 3'h7, 1'h0, 4'h4, 6'h0},
        '{OP_CMPI, 32'h0, 32'h1, 16'h8000, 3'h4, 1'h1, 4'h5, 6'h0},
        '{OP_CMP, 32'h7fffffff, 32'h80000000, 16'h0, 3'h5, 1'h0, 4'h4, 6'h0},
        '{OP_CMPL, 32'h7fffffff, 32'h80000000, 16'h0, 3'h6, 1'h0, 4'h8, 6'h0},
        '{OP_CMPL, 32'h12345678, 32'h12345678, 16'h0, 3'h0, 1'h1, 4'h3, 6'h0},
        '{OP_CLZ, 32'h0, 32'h1, 16'h0, 3'h0, 1'h0, 4'h4, 6'h20},
        '{OP_CLZ, 32'h80000000, 32'h1, 16'h0, 3'h0, 1'h0, 4'h2, 6'h0},
        '{OP_CLZ, 32'h00010000, 32'h1, 16'h0, 3'h0, 1'h0, 4'h4, 6'h0f}};
    cflu_op_t fops [5] = '{OP_FAND, OP_FANDC, OP_FNAND, OP_FEQV, OP_FNOR};
    logic [4:0] fexp = 5'h06;
    logic sys_clk = 1'h0, reset = 1'h1, issue = 1'h0, so = 1'h0, flagsWe = 1'h0, linkWe = 1'h0, cmdValid;
    logic [31:0] srcA = 32'h0, srcB = 32'h0, pc = 32'h0, conditionFlags, returnLink;
    cflu_cmd_t k = '0, cmd;
    cflu_result_t result;
    int bad_count = 0, n_checks = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    cflu_decode_model i_dec (.issue(issue), .issueCmd(k), .cmdValid(cmdValid), .cmd(cmd));
    cflu_core i_dut (.sys_clk(sys_clk), .reset(reset), .cmdValid(cmdValid), .cmd(cmd), .firstSourceGpr(srcA),
        .secondSourceGpr(srcB), .currentFetchAddr(pc), .lowInstrBit(1'h0), .summaryOverflow(so),
        .flagsWriteEn(flagsWe), .flagsWriteData(32'ha0000000), .linkWriteEn(linkWe), .linkWriteData(32'h1237),
        .result(result), .conditionFlags(conditionFlags), .returnLink(returnLink));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic exec(input logic [31:0] a);
        @(negedge sys_clk);
        srcA = a;
        issue = 1'h1;
        @(negedge sys_clk);
        issue = 1'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        chk("flags in reset", 32'h0, conditionFlags);
        chk("result in reset", 32'h0, result.gprData);
        $display("reset test done");
        reset = 1'h0;
        foreach (rows[i]) begin
            k = '0;
            k.op = rows[i].op;
            k.literalOperand = rows[i].imm;
            k.destFieldSel = rows[i].fld;
            k.recordFlag = 1'h1;
            so = rows[i].so;
            srcB = rows[i].b;
            exec(rows[i].a);
            chk("field", {28'h0, rows[i].f}, {28'h0, conditionFlags[31-4*rows[i].fld -: 4]});
            chk("count", {26'h0, rows[i].n}, result.gprData);
            $display("row %0d done", i);
        end
        flagsWe = 1'h1;
        linkWe = 1'h1;
        @(negedge sys_clk);
        flagsWe = 1'h0;
        linkWe = 1'h0;
        foreach (fops[i]) begin
            k = '0;
            k.op = fops[i];
            k.destFlagPos = 5'h4;
            k.secondFlagSel = 5'h1;
            exec(32'h0);
            chk("flag op", 32'ha0000000 | ({31'h0, fexp[i]} << 27), conditionFlags);
        end
        k = '0;
        k.op = OP_FEQV;
        k.destFlagPos = 5'h5;
        k.firstFlagSel = 5'h5;
        k.secondFlagSel = 5'h5;
        exec(32'h0);
        chk("same bit equivalence", 32'ha4000000, conditionFlags);
        $display("flag tests done");
        for (int i = 0; i < 4; i++) begin
            pc = 32'h100 * (i + 1);
            k = '0;
            k.op = OP_BRLINK;
            k.linkFlag = 1'h1;
            k.branchOptions = (i == 0) ? OPT_IF_TRUE : (i == 3) ? 5'h14 : OPT_IF_FALSE;
            k.testedFlagIndex = (i == 2) ? 5'h1 : 5'h0;
            exec(32'h0);
            chk("taken", {31'h0, i != 1 && i != 3}, {31'h0, result.branchTaken});
            chk("target", (i == 0) ? 32'h1234 : 32'h100 * i + 32'h4, result.branchTarget);
            chk("link", (i == 3) ? 32'h304 : 32'h100 * (i + 1) + 32'h4, returnLink);
            chk("refused", {31'h0, i == 3}, {31'h0, result.invalidForm});
        end
        k = '0;
        k.op = OP_CMP;
        k.sizeBit = 1'h1;
        exec(32'h5);
        chk("size refused", 32'h1, {31'h0, result.invalidForm});
        chk("flags kept", 32'ha4000000, conditionFlags);
        k = '0;
        k.op = OP_CLZ;
        exec(32'h0);
        chk("unrecorded count", 32'h20, result.gprData);
        chk("unrecorded flags", 32'ha4000000, conditionFlags);
        $display("branch and refusal tests done");
        end_of_test();
    end
endmodule
`default_nettype wire
